// ===== rtl/vipr_responder.sv
// inquiry vital-product-data page responder: pages 00h, 03h and 80h as a byte stream
`include "vipr_regs.svh"

module vipr_responder (
    input wire logic CLK,
    input wire logic RST,
    input vipr_pkg::vipr_req_s REQ,
    output logic REQ_READY,
    input vipr_pkg::vipr_fw_info_s FW_INFO,
    output vipr_pkg::vipr_stream_s OUT,
    input wire logic OUT_READY,
    output vipr_pkg::vipr_resp_s RESP,
    output logic BUSY
);
    import vipr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // field helpers

    function automatic logic is_alnum(input logic [7:0] c);
        is_alnum = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h5A) || (c >= 8'h61 && c <= 8'h7A);
    endfunction : is_alnum

    function automatic logic is_hex(input logic [7:0] c);
        is_hex = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
    endfunction : is_hex

    // left-justify the microcode id: alphanumerics keep their order, stray characters are
    // squeezed out so the producer cannot leave a gap at the front, the tail is space filled
    function automatic logic [7:0] ucode_left(input logic [11:0][7:0] id, input logic [7:0] r);
        logic [7:0] n;
        n = 8'h00;
        ucode_left = `VIPR_ASCII_SPACE;
        for (int i = 11; i >= 0; i--)
        begin
            if (is_alnum(id[i]))
            begin
                if (n == r)
                    ucode_left = id[i];
                n = n + 8'h01;
            end
        end
    endfunction : ucode_left

    // big-endian byte k of a 32-bit value
    function automatic logic [7:0] be32(input logic [31:0] v, input logic [1:0] k);
        be32 = v[8'(31 - 8 * k) -: 8];
    endfunction : be32

    function automatic logic is_supported(input logic [7:0] p);
        is_supported = (p == `VIPR_PAGE_SUPPORTED) || (p == `VIPR_PAGE_FIRMWARE) || (p == `VIPR_PAGE_SERIAL);
    endfunction : is_supported

    function automatic logic [7:0] page_len(input logic [7:0] p);
        case (p)
            `VIPR_PAGE_SUPPORTED: page_len = `VIPR_LEN_SUPPORTED; // see R4
            `VIPR_PAGE_FIRMWARE: page_len = `VIPR_LEN_FIRMWARE; // see R5
            `VIPR_PAGE_SERIAL: page_len = `VIPR_LEN_SERIAL; // see R19
            default: page_len = `VIPR_RST_BYTE;
        endcase
    endfunction : page_len

    ////////////////////////////////////////////////////////////////////////////////
    // firmware page body, bytes 4 and up

    function automatic logic [7:0] fw_byte(input logic [7:0] idx, input vipr_fw_info_s f);
        logic [7:0] r;
        logic [7:0] c;
        r = 8'h00;
        c = 8'h00;
        fw_byte = 8'h00;
        if (idx >= `VIPR_OFF_UCODE && idx < `VIPR_OFF_SERVO)
        begin
            r = idx - `VIPR_OFF_UCODE;
            fw_byte = ucode_left(f.ucode_id, r); // see R7
        end
        else if (idx >= `VIPR_OFF_SERVO && idx < `VIPR_OFF_MAJOR)
        begin
            r = idx - `VIPR_OFF_SERVO;
            c = f.servo_pn[2'(8'd3 - r)];
            fw_byte = is_hex(c) ? c : `VIPR_ASCII_ZERO; // see R8
        end
        else if (idx >= `VIPR_OFF_MAJOR && idx < `VIPR_OFF_UCOUNT)
        begin
            r = idx - `VIPR_OFF_MAJOR;
            fw_byte = be32({f.major, f.minor}, r[1:0]); // see R9
        end
        else if (idx >= `VIPR_OFF_UCOUNT && idx < `VIPR_OFF_BUILD)
        begin
            r = idx - `VIPR_OFF_UCOUNT;
            fw_byte = be32(f.user_count, r[1:0]); // see R10
        end
        else if (idx >= `VIPR_OFF_BUILD && idx < `VIPR_OFF_DATE)
        begin
            r = idx - `VIPR_OFF_BUILD;
            fw_byte = be32(f.build_num, r[1:0]); // see R10
        end
        else if (idx >= `VIPR_OFF_DATE && idx < `VIPR_OFF_PRODUCT)
        begin
            r = idx - `VIPR_OFF_DATE;
            fw_byte = f.build_date[5'(8'd31 - r)]; // see R10
        end
        else if (idx >= `VIPR_OFF_PRODUCT && idx < `VIPR_OFF_IFACE)
        begin
            r = idx - `VIPR_OFF_PRODUCT;
            fw_byte = f.product[3'(8'd7 - r)]; // see R11
        end
        else if (idx >= `VIPR_OFF_IFACE && idx < `VIPR_OFF_CTYPE)
        begin
            r = idx - `VIPR_OFF_IFACE;
            fw_byte = f.interface_id[3'(8'd7 - r)]; // see R11
        end
        else if (idx >= `VIPR_OFF_CTYPE && idx < `VIPR_OFF_UNAME)
        begin
            r = idx - `VIPR_OFF_CTYPE;
            fw_byte = f.code_type[3'(8'd7 - r)]; // see R11
        end
        else if (idx >= `VIPR_OFF_UNAME && idx < `VIPR_OFF_MACHINE)
        begin
            r = idx - `VIPR_OFF_UNAME;
            fw_byte = f.user_name[4'(8'd11 - r)];
        end
        else if (idx >= `VIPR_OFF_MACHINE && idx < `VIPR_OFF_DIR)
        begin
            r = idx - `VIPR_OFF_MACHINE;
            fw_byte = f.machine[4'(8'd15 - r)];
        end
        else if (idx >= `VIPR_OFF_DIR && idx < `VIPR_OFF_OPSTATE)
        begin
            // the producer keeps only the path tail; a shorter path arrives space filled
            r = idx - `VIPR_OFF_DIR;
            fw_byte = f.dir_name[5'(8'd31 - r)]; // see R12
        end
        else if (idx >= `VIPR_OFF_OPSTATE && idx < `VIPR_OFF_FUNC)
        begin
            r = idx - `VIPR_OFF_OPSTATE;
            fw_byte = be32({24'h000000, f.op_state}, r[1:0]); // see R13, see R14
        end
        else if (idx >= `VIPR_OFF_FUNC && idx < `VIPR_OFF_DEGRADED)
        begin
            r = idx - `VIPR_OFF_FUNC;
            fw_byte = be32({24'h000000, f.func_mode}, r[1:0]); // see R15
        end
        else if (idx >= `VIPR_OFF_DEGRADED && idx < `VIPR_OFF_BROKEN)
        begin
            r = idx - `VIPR_OFF_DEGRADED;
            fw_byte = be32(f.degraded, r[1:0]); // see R16
        end
        else if (idx >= `VIPR_OFF_BROKEN && idx < `VIPR_OFF_CMODE)
        begin
            r = idx - `VIPR_OFF_BROKEN;
            fw_byte = be32(f.broken, r[1:0]); // see R16
        end
        else if (idx >= `VIPR_OFF_CMODE && idx < `VIPR_OFF_FLASHREV)
        begin
            r = idx - `VIPR_OFF_CMODE;
            fw_byte = be32({24'h000000, f.code_mode}, r[1:0]); // see R17
        end
        else if (idx >= `VIPR_OFF_FLASHREV)
        begin
            r = idx - `VIPR_OFF_FLASHREV;
            fw_byte = be32(f.flash_rev, r[1:0]); // see R18
        end
    endfunction : fw_byte

    ////////////////////////////////////////////////////////////////////////////////
    // one byte of any page image

    function automatic logic [7:0] page_byte(input logic [7:0] p, input logic [7:0] idx,
                                             input vipr_fw_info_s f);
        logic [7:0] r;
        logic [119:0] list;
        r = idx - `VIPR_HDR_SIZE;
        list = `VIPR_SUPP_LIST;
        page_byte = 8'h00;
        case (idx)
            `VIPR_POS_QUAL: page_byte = `VIPR_HDR_BYTE0; // see R1
            `VIPR_POS_PAGE: page_byte = p; // see R2
            `VIPR_POS_RSVD: page_byte = 8'h00;
            `VIPR_POS_LEN: page_byte = page_len(p); // see R6
            default:
            begin
                case (p)
                    `VIPR_PAGE_SUPPORTED:
                        page_byte = list[7'(8'd119 - 8'd8 * r) -: 8]; // see R3, see R4
                    `VIPR_PAGE_FIRMWARE:
                        page_byte = fw_byte(idx, f);
                    `VIPR_PAGE_SERIAL:
                    begin
                        // low elements hold the right end of the number
                        if ({1'b0, 4'(8'd15 - r)} < f.serial_len)
                            page_byte = f.serial[4'(8'd15 - r)]; // see R20
                        else
                            page_byte = `VIPR_ASCII_SPACE;
                    end
                    default: page_byte = 8'h00;
                endcase
            end
        endcase
    endfunction : page_byte

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer

    vipr_state_s cur;
    vipr_state_s next_cur;
    logic [7:0] total;
    logic [7:0] n_send;
    logic take;
    logic [7:0] cur_byte;

    always_comb
    begin
        next_cur = cur;
        next_cur.resp = '0;
        total = page_len(REQ.page) + `VIPR_HDR_SIZE;
        // truncation shortens the stream only, never the length byte
        n_send = (REQ.alloc < {8'h00, total}) ? REQ.alloc[7:0] : total; // see R6
        take = !cur.out.valid || OUT_READY;
        cur_byte = page_byte(cur.page, cur.idx, FW_INFO);
        case (cur.st)
            ST_IDLE:
            begin
                if (REQ.valid && cur.req_ready)
                begin
                    if (!is_supported(REQ.page))
                    begin
                        next_cur.resp.check = 1'b1; // see R21
                        next_cur.resp.done = 1'b1;
                    end
                    else if (n_send == 8'h00)
                        next_cur.resp.done = 1'b1;
                    else
                    begin
                        next_cur.req_ready = 1'b0;
                        next_cur.busy = 1'b1;
                        next_cur.page = REQ.page;
                        next_cur.idx = 8'h00;
                        next_cur.count = n_send;
                        next_cur.st = ST_SEND;
                    end
                end
            end
            ST_SEND:
            begin
                if (take)
                begin
                    next_cur.out.valid = 1'b1;
                    next_cur.out.data = cur_byte;
                    next_cur.out.last = (cur.idx == cur.count - 8'h01);
                    next_cur.idx = cur.idx + 8'h01;
                    if (cur.idx == cur.count - 8'h01)
                        next_cur.st = ST_CLOSE;
                end
            end
            ST_CLOSE:
            begin
                // hold the final byte until the sink takes it
                if (OUT_READY)
                begin
                    next_cur.out = '0;
                    next_cur.resp.done = 1'b1;
                    next_cur.req_ready = 1'b1;
                    next_cur.busy = 1'b0;
                    next_cur.st = ST_IDLE;
                end
            end
            default:
            begin
                next_cur = '0;
                next_cur.st = ST_IDLE;
                next_cur.req_ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            cur <= '{st: ST_IDLE, page: `VIPR_RST_BYTE, idx: `VIPR_RST_BYTE, count: `VIPR_RST_BYTE,
                     out: '0, resp: '0, req_ready: 1'b1, busy: 1'b0};
        end
        else
            cur <= next_cur;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign OUT = cur.out;
    assign RESP = cur.resp;
    assign REQ_READY = cur.req_ready;
    assign BUSY = cur.busy;

endmodule : vipr_responder

// ===== rtl/vipr_regs.svh
// constants for the vital-product-data inquiry page responder
// Behaviour
// R1 - byte 0 of every page: qualifier 0, peripheral device type 0 (direct access).
// R2 - byte 1 echoes the page code the initiator asked for.
// R3 - supported-pages page lists each supported code, one per byte, ascending.
// R4 - list holds fifteen codes 00h through D2h, page length 0Fh.
// R5 - firmware page reports page length 188 in byte 3.
// R6 - short allocation truncates the transfer, page length stays unadjusted.
// R7 - microcode identifier bytes 24-35 alphanumeric, left aligned, space padded.
// R8 - servo part number bytes 36-39 hold only hex ASCII characters.
// R9 - major version in bytes 40-41, minor version in bytes 42-43.
// R10 - build count 44-47, master build number 48-51, build date 52-83.
// R11 - product name 84-91, interface and speed 92-99, code use 100-107.
// R12 - bytes 136-167 hold last 32 characters of the build directory.
// R13 - operating state codes 0 to 5 in bytes 168-171.
// R14 - operating state codes 6, 7, 8, 10 and 11.
// R15 - functional mode low byte: 0 plain, 1 special command mode.
// R16 - degraded cause 176-179, broken cause 180-183, same error-class encoding.
// R17 - code mode 184-187: 0 rom, 1 overlay, 2 media, 3 unsaved download.
// R18 - flash firmware revision level in bytes 188-191.
// R19 - serial-number page length byte is 16 (10h).
// R20 - serial number right aligned after the header.
// R21 - unsupported page code answers check condition, no page data.
// R22 - initiator re-issues with larger allocation when page length exceeds bytes received.
`ifndef VIPR_REGS_SVH
`define VIPR_REGS_SVH

`define VIPR_PAGE_SUPPORTED 8'h00
`define VIPR_PAGE_FIRMWARE 8'h03
`define VIPR_PAGE_SERIAL 8'h80
`define VIPR_HDR_BYTE0 8'h00
`define VIPR_HDR_SIZE 8'h04
`define VIPR_POS_QUAL 8'h00
`define VIPR_POS_PAGE 8'h01
`define VIPR_POS_RSVD 8'h02
`define VIPR_POS_LEN 8'h03
`define VIPR_LEN_SUPPORTED 8'h0F
`define VIPR_LEN_FIRMWARE 8'hBC
`define VIPR_LEN_SERIAL 8'h10
`define VIPR_SUPP_LIST 120'h00_03_80_83_86_87_88_8A_90_91_B0_B1_B2_D1_D2

`define VIPR_OFF_UCODE 8'h18
`define VIPR_OFF_SERVO 8'h24
`define VIPR_OFF_MAJOR 8'h28
`define VIPR_OFF_MINOR 8'h2A
`define VIPR_OFF_UCOUNT 8'h2C
`define VIPR_OFF_BUILD 8'h30
`define VIPR_OFF_DATE 8'h34
`define VIPR_OFF_PRODUCT 8'h54
`define VIPR_OFF_IFACE 8'h5C
`define VIPR_OFF_CTYPE 8'h64
`define VIPR_OFF_UNAME 8'h6C
`define VIPR_OFF_MACHINE 8'h78
`define VIPR_OFF_DIR 8'h88
`define VIPR_OFF_OPSTATE 8'hA8
`define VIPR_OFF_FUNC 8'hAC
`define VIPR_OFF_DEGRADED 8'hB0
`define VIPR_OFF_BROKEN 8'hB4
`define VIPR_OFF_CMODE 8'hB8
`define VIPR_OFF_FLASHREV 8'hBC

`define VIPR_ASCII_SPACE 8'h20
`define VIPR_ASCII_ZERO 8'h30
`define VIPR_RST_BYTE 8'h00

`endif

// ===== rtl/vipr_pkg.sv
// types shared by the inquiry page responder and its users
package vipr_pkg;

    typedef enum logic [7:0] {
        state_hw_failed = 8'h00,
        state_soft_failed = 8'h01,
        state_motor_stopped = 8'h02,
        state_motor_starting = 8'h03,
        state_spun_unloaded = 8'h04,
        state_ready = 8'h05,
        state_low_power = 8'h06,
        state_halted_after_ready = 8'h07,
        state_awaiting_link_notify = 8'h08,
        state_quiet_spinup = 8'h0A,
        state_notify_then_spinup = 8'h0B
    } vipr_op_state_e;

    typedef enum logic [7:0] {
        func_plain = 8'h00,
        func_special_commands = 8'h01
    } vipr_func_mode_e;

    typedef enum logic [7:0] {
        code_from_rom = 8'h00,
        code_rom_overlay = 8'h01,
        code_from_media = 8'h02,
        code_unsaved_download = 8'h03
    } vipr_code_mode_e;

    typedef logic [31:0] vipr_error_class_code_t;

    // string fields: element [N-1] is the first byte on the wire
    typedef struct packed {
        logic [11:0][7:0] ucode_id;
        logic [3:0][7:0] servo_pn;
        logic [15:0] major;
        logic [15:0] minor;
        logic [31:0] user_count;
        logic [31:0] build_num;
        logic [31:0][7:0] build_date;
        logic [7:0][7:0] product;
        logic [7:0][7:0] interface_id;
        logic [7:0][7:0] code_type;
        logic [11:0][7:0] user_name;
        logic [15:0][7:0] machine;
        logic [31:0][7:0] dir_name;
        vipr_op_state_e op_state;
        vipr_func_mode_e func_mode;
        vipr_error_class_code_t degraded;
        vipr_error_class_code_t broken;
        vipr_code_mode_e code_mode;
        logic [31:0] flash_rev;
        logic [15:0][7:0] serial;
        logic [4:0] serial_len;
    } vipr_fw_info_s;

    typedef struct packed {
        logic valid;
        logic [7:0] page;
        logic [15:0] alloc;
    } vipr_req_s;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
    } vipr_stream_s;

    typedef struct packed {
        logic done;
        logic check;
    } vipr_resp_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_SEND = 3'h2,
        ST_CLOSE = 3'h4
    } vipr_state_e;

    typedef struct packed {
        vipr_state_e st;
        logic [7:0] page;
        logic [7:0] idx;
        logic [7:0] count;
        vipr_stream_s out;
        vipr_resp_s resp;
        logic req_ready;
        logic busy;
    } vipr_state_s;

endpackage : vipr_pkg

// ===== dv/vipr_responder_checker.sv
// port assertions for the inquiry page responder
module vipr_responder_checker (
    input wire logic CLK,
    input wire logic RST,
    input vipr_pkg::vipr_req_s REQ,
    input wire logic REQ_READY,
    input vipr_pkg::vipr_fw_info_s FW_INFO,
    input vipr_pkg::vipr_stream_s OUT,
    input wire logic OUT_READY,
    input vipr_pkg::vipr_resp_s RESP,
    input wire logic BUSY
);
timeunit 1ns;
timeprecision 1ps;
import vipr_pkg::*;
default clocking @(posedge CLK);
endclocking
default disable iff (RST);
////////////////////////////////////////////////////////////////////////
wire take = REQ.valid && REQ_READY;
wire supp = REQ.page == 8'h00 || REQ.page == 8'h03 || REQ.page == 8'h80;
wire acc = OUT.valid && OUT_READY;
logic [7:0] pg, idx, prv, ln;
logic [15:0] al, nb;
// idx counts bytes accepted since the command was taken
always_ff @(posedge CLK or posedge RST)
begin
    if (RST)
        {pg, idx, prv, al} <= '0;
    else if (take)
        {pg, idx, al} <= {REQ.page, 8'h00, REQ.alloc};
    else if (acc)
        {idx, prv} <= {idx + 8'h01, OUT.data};
end
always_comb ln = pg == 8'h03 ? 8'hBC : (pg == 8'h80 ? 8'h10 : 8'h0F);
always_comb nb = (al < {8'h00, ln} + 16'h0004) ? al : {8'h00, ln} + 16'h0004;
////////////////////////////////////////////////////////////////////////
a_reject_check: assert property (take && !supp |=> RESP.done && RESP.check && REQ_READY && !OUT.valid)
    else $error("unsupported page not rejected");
a_zero_alloc: assert property (take && supp && REQ.alloc == 16'h0000 |=> RESP.done && !RESP.check && REQ_READY)
    else $error("zero allocation not closed at once");
a_first_byte: assert property (take && supp && REQ.alloc != 16'h0000 |=> BUSY && !REQ_READY ##1 OUT.valid && OUT.data == 8'h00)
    else $error("first byte late or not zero");
a_page_echo: assert property (OUT.valid && idx == 8'h01 |-> OUT.data == pg)
    else $error("page code not echoed");
a_length_byte: assert property (OUT.valid && idx == 8'h03 |-> OUT.data == ln)
    else $error("page length byte wrong");
a_list_ascend: assert property (OUT.valid && pg == 8'h00 && idx > 8'h04 |-> OUT.data > prv)
    else $error("supported list not ascending");
a_last_count: assert property (OUT.valid && OUT.last |-> {8'h00, idx} + 16'h0001 == nb)
    else $error("transfer length wrong");
a_stall_hold: assert property (OUT.valid && !OUT_READY |=> OUT.valid && $stable(OUT.data) && $stable(OUT.last))
    else $error("byte dropped under stall");
a_done_after: assert property (acc && OUT.last |=> RESP.done && !RESP.check && REQ_READY ##1 !RESP.done)
    else $error("done pulse missing after last byte");
a_op_state: assert property (OUT.valid && pg == 8'h03 && idx == 8'hAB |-> OUT.data == FW_INFO.op_state)
    else $error("operating state byte wrong");
a_func_mode: assert property (OUT.valid && pg == 8'h03 && idx == 8'hAF |-> OUT.data == FW_INFO.func_mode)
    else $error("functional mode byte wrong");
a_code_mode: assert property (OUT.valid && pg == 8'h03 && idx == 8'hBB |-> OUT.data == FW_INFO.code_mode)
    else $error("code mode byte wrong");
c_reject: cover property (take && !supp);
c_full_fw: cover property (acc && OUT.last && pg == 8'h03);
c_stall: cover property (OUT.valid && !OUT_READY);
endmodule : vipr_responder_checker

bind vipr_responder vipr_responder_checker u_vipr_responder_checker (.CLK(CLK), .RST(RST), .REQ(REQ),
    .REQ_READY(REQ_READY), .FW_INFO(FW_INFO), .OUT(OUT), .OUT_READY(OUT_READY), .RESP(RESP), .BUSY(BUSY));

// ===== dv/vipr_host_model.sv
// initiator side byte sink with optional back-pressure
module vipr_host_model (
    input wire logic clk,
    input wire logic stall,
    input vipr_pkg::vipr_stream_s stream,
    output logic ready
);
timeunit 1ns;
timeprecision 1ps;
logic [7:0] got [0:255];
int n_got = 0;
logic [1:0] ph = 2'h0;
initial ready = 1'b1;
// a stalling sink takes one byte in four so held bytes are seen often
always @(negedge clk)
begin
    ph <= ph + 2'h1;
    ready <= !stall || ph == 2'h0;
end
always @(posedge clk)
begin
    if (stream.valid && ready)
    begin
        got[n_got[7:0]] <= stream.data;
        n_got <= n_got + 1;
    end
end
task clear();
    n_got = 0;
endtask : clear
endmodule : vipr_host_model

// ===== dv/vipr_responder_tb.sv
// self-checking testbench for the inquiry page responder
module vipr_responder_tb;
timeunit 1ns;
timeprecision 1ps;
import vipr_pkg::*;
logic CLK = 1'b0;
logic RST = 1'b1;
logic stall = 1'b0;
vipr_req_s REQ = '0;
vipr_fw_info_s FW_INFO = '0;
logic REQ_READY, OUT_READY, BUSY;
vipr_stream_s OUT;
vipr_resp_s RESP;
logic [1535:0] e = '0;
logic [87:0] opc = 88'h00_01_02_03_04_05_06_07_08_0A_0B;
logic [31:0] bad = 32'h8301FF02;
int n_mismatch = 0;
int n_checks = 0;
always #4 CLK = ~CLK;
vipr_responder u_vipr_responder (.CLK(CLK), .RST(RST), .REQ(REQ), .REQ_READY(REQ_READY), .FW_INFO(FW_INFO),
    .OUT(OUT), .OUT_READY(OUT_READY), .RESP(RESP), .BUSY(BUSY));
vipr_host_model u_vipr_host_model (.clk(CLK), .stall(stall), .stream(OUT), .ready(OUT_READY));
////////////////////////////////////////////////////////////////////////
task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
        n_mismatch++;
        $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
endtask : chk

task end_of_test();
    if (n_mismatch == 0 && n_checks > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
endtask : end_of_test

// one command: expected bytes come from e, nf is the full page size
task run(input logic [7:0] pg, input logic [15:0] al, input int nf, input logic ck);
    int n;
    int k;
    n = (al < nf) ? al : nf;
    u_vipr_host_model.clear();
    @(negedge CLK);
    REQ = '{1'b1, pg, al};
    @(negedge CLK);
    REQ.valid = 1'b0;
    k = 0;
    while (RESP.done !== 1'b1 && k < 1000)
    begin
        @(negedge CLK);
        k++;
    end
    chk("done", RESP.done, 1);
    chk("check", RESP.check, ck);
    chk("count", u_vipr_host_model.n_got, n);
    for (int i = 0; i < n; i++)
        chk($sformatf("byte %0d", i), u_vipr_host_model.got[i], e[1535 - 8 * i -: 8]);
endtask : run
////////////////////////////////////////////////////////////////////////
initial
begin
    FW_INFO.ucode_id = {"FW7X", {8{8'h20}}};
    FW_INFO.servo_pn = "1A9F";
    FW_INFO.major = 16'h0102;
    FW_INFO.minor = 16'h0304;
    FW_INFO.user_count = 32'h05060708;
    FW_INFO.build_num = 32'h090A0B0C;
    FW_INFO.build_date = {8{"MNOP"}};
    FW_INFO.product = "PRODNAME";
    FW_INFO.interface_id = "SAS 12G ";
    FW_INFO.code_type = "RELEASED";
    FW_INFO.user_name = {3{"USER"}};
    FW_INFO.machine = {4{"HOST"}};
    FW_INFO.dir_name = {8{"/src"}};
    FW_INFO.degraded = 32'h11223344;
    FW_INFO.broken = 32'h55667788;
    FW_INFO.flash_rev = 32'h0A0B0C0D;
    FW_INFO.serial = {80'h0, "SN1234"};
    FW_INFO.serial_len = 5'h06;
    repeat (5) @(negedge CLK);
    RST = 1'b0;
    e[1535 -: 152] = {32'h0000000F, 120'h00_03_80_83_86_87_88_8A_90_91_B0_B1_B2_D1_D2};
    run(8'h00, 16'd255, 19, 1'b0);
    run(8'h00, 16'd0, 19, 1'b0);
    e[1535 -: 160] = {32'h00800010, {10{8'h20}}, "SN1234"};
    run(8'h80, 16'd20, 20, 1'b0);
    run(8'h80, 16'd2, 20, 1'b0);
    // rejected pages back to back, including a listed code that is not built
    for (int i = 0; i < 4; i++)
        run(bad[31 - 8 * i -: 8], 16'd255, 0, 1'b1);
    for (int i = 0; i < 11; i++)
    begin
        FW_INFO.op_state = vipr_op_state_e'(opc[87 - 8 * i -: 8]);
        FW_INFO.func_mode = vipr_func_mode_e'(8'(i % 2));
        FW_INFO.code_mode = vipr_code_mode_e'(8'(i % 4));
        stall = i[0];
        e = {32'h000300BC, 160'h0, FW_INFO[1404 -: 1152], 24'h0, opc[87 - 8 * i -: 8], 24'h0, 8'(i % 2),
            FW_INFO.degraded, FW_INFO.broken, 24'h0, 8'(i % 4), FW_INFO.flash_rev};
        if (i == 0)
            run(8'h03, 16'd4, 192, 1'b0);
        run(8'h03, 16'd300, 192, 1'b0);
    end
    // stray characters are squeezed out of the id, non-hex servo digits shown as zero
    FW_INFO.ucode_id = {" FW-7X", {6{8'h20}}};
    FW_INFO.servo_pn = "1a9G";
    e[1343 -: 128] = {"FW7X", {8{8'h20}}, "1090"};
    run(8'h03, 16'h012C, 192, 1'b0);
    // a reset in the middle of a stalled page must drop it and leave the block idle
    stall = 1'b1;
    @(negedge CLK);
    REQ = '{1'b1, 8'h03, 16'h012C};
    @(negedge CLK);
    REQ.valid = 1'b0;
    repeat (20) @(negedge CLK);
    chk("busy mid page", BUSY, 1);
    chk("ready mid page", REQ_READY, 0);
    RST = 1'b1;
    @(negedge CLK);
    chk("ready in reset", REQ_READY, 1);
    chk("busy in reset", BUSY, 0);
    chk("valid in reset", OUT.valid, 0);
    RST = 1'b0;
    stall = 1'b0;
    e[1535 -: 160] = {32'h00800010, {10{8'h20}}, "SN1234"};
    run(8'h80, 16'h0014, 20, 1'b0);
    end_of_test();
end

// whole run is a few thousand cycles; this leaves ample margin
initial
begin
    #200000;
    n_mismatch++;
    end_of_test();
end
endmodule : vipr_responder_tb
